//--- src/gpio_port_pkg.sv
// constants and types shared by the port one gpio block
package gpio_port_pkg;

   // ==========================================================
   // types
   typedef logic [7:0] port_byte_t;

   // ==========================================================
   // register byte addresses
   localparam logic [15:0] OFF_PIN_FUNCTION_SELECT = 16'hFFC8;
   localparam logic [15:0] OFF_PORT_OUTPUT_DATA    = 16'hFFD4;
   localparam logic [15:0] OFF_PULLUP_ENABLE       = 16'hFFE0;
   localparam logic [15:0] OFF_PIN_DIRECTION       = 16'hFFE4;
   localparam int          MIN_ADDR_W              = 16;

   // ==========================================================
   // reset and readback values
   localparam port_byte_t  RST_PIN_FUNCTION_SELECT = 8'h00;
   localparam port_byte_t  RST_PORT_OUTPUT_DATA    = 8'h00;
   localparam port_byte_t  RST_PULLUP_ENABLE       = 8'h00;
   localparam port_byte_t  RST_PIN_DIRECTION       = 8'h00;
   localparam port_byte_t  DIRECTION_READBACK      = 8'hFF;
   localparam logic [23:0] READ_PAD                = 24'h000000;

   // ==========================================================
   // function select fields
   localparam int          SEL_EXT_INT_THREE       = 7;
   localparam int          SEL_EXT_INT_TWO         = 6;
   localparam int          SEL_EXT_INT_ONE         = 5;
   localparam int          SEL_PWM_OUT             = 4;
   localparam int          SEL_TIMER_G_INPUT       = 3;
   localparam int          SEL_TIMER_F_HIGH_OUT    = 2;
   localparam int          SEL_TIMER_F_LOW_OUT     = 1;
   localparam int          SEL_WATCH_TIMER_OUT     = 0;
   localparam port_byte_t  ALT_OUTPUT_PINS         = 8'h17;
   localparam port_byte_t  ALT_INPUT_PINS          = 8'hE8;

   // ==========================================================
   // event vector positions
   localparam int          EVT_TIMER_F             = 3;
   localparam int          EVT_TIMER_C             = 2;
   localparam int          EVT_TIMER_B             = 1;
   localparam int          EVT_TIMER_G             = 0;

endpackage : gpio_port_pkg

//--- src/pin_mux_if.sv
// signals between the register side and the pin multiplexer
`timescale 1ns/1ps
interface pin_mux_if;
   import gpio_port_pkg::*;

   port_byte_t  port_output_data;
   port_byte_t  pin_direction;
   port_byte_t  pullup_enable;
   port_byte_t  pin_function_select;
   port_byte_t  pin_level;
   port_byte_t  alt_source;
   port_byte_t  next_pin_out;
   port_byte_t  next_pin_oe;
   port_byte_t  next_pullup;
   logic [3:0]  next_events;

   modport regs (
      output port_output_data, pin_direction, pullup_enable,
      output pin_function_select, pin_level, alt_source,
      input  next_pin_out, next_pin_oe, next_pullup, next_events
   );

   modport mux (
      input  port_output_data, pin_direction, pullup_enable,
      input  pin_function_select, pin_level, alt_source,
      output next_pin_out, next_pin_oe, next_pullup, next_events
   );

endinterface : pin_mux_if

//--- src/pin_mux.sv
// per pin routing of gpio and alternate functions
`timescale 1ns/1ps
module pin_mux (
   pin_mux_if.mux bus
);
   import gpio_port_pkg::*;

   // ==========================================================
   // per pin drive selection
   for (genvar i = 0; i < 8; i++) begin : g_pin
      wire alt_out = ALT_OUTPUT_PINS[i] & bus.pin_function_select[i];
      wire alt_in  = ALT_INPUT_PINS[i] & bus.pin_function_select[i];
      wire gpio    = ~alt_out & ~alt_in;

      // alternate output ignores direction bit
      assign bus.next_pin_oe[i]  = alt_out | (gpio & bus.pin_direction[i]);
      assign bus.next_pin_out[i] = alt_out ? bus.alt_source[i]
                                 : (gpio & bus.port_output_data[i]);
      assign bus.next_pullup[i]  = ~bus.pin_direction[i] & bus.pullup_enable[i];
   end

   // ==========================================================
   // input routing toward interrupt and timer units
   assign bus.next_events[EVT_TIMER_F] = bus.pin_function_select[7]
                                       & bus.pin_level[7];
   assign bus.next_events[EVT_TIMER_C] = bus.pin_function_select[6]
                                       & bus.pin_level[6];
   assign bus.next_events[EVT_TIMER_B] = bus.pin_function_select[5]
                                       & bus.pin_level[5];
   assign bus.next_events[EVT_TIMER_G] = bus.pin_function_select[3]
                                       & bus.pin_level[3];

endmodule : pin_mux

//--- src/port_one_gpio.sv
// port one gpio with pin function multiplexer and wishbone registers
// Summary of operation
// - eight pins, seven down to zero, each usable as input or output
// - output data bit is the level driven on an output pin
// - direction one: data read returns the stored latch bit
// - direction zero: data read returns the sampled pin level
// - direction one makes the pin output, zero makes it input
// - direction and data only set the drive of pins selected as gpio; direction gates pull-up on every pin
// - direction register is write only and reads as all ones
// - pull-up on only when direction zero and pull-up enable one
// - reset clears data, direction, pull-up and function select
// - select bits seven to five route pins as interrupt and timer inputs
// - edge choice for those inputs lives in other units
// - select bits four to zero: pwm, timer input, three timer outputs
`timescale 1ns/1ps
module port_one_gpio #(
   parameter int ADDR_W = 16
) (
   input  wire  logic                      clock,
   input  wire  logic                      sys_rst,
   input  wire  logic                      wb_cyc_i,
   input  wire  logic                      wb_stb_i,
   input  wire  logic                      wb_we_i,
   input  wire  logic [ADDR_W-1:0]         wb_adr_i,
   input  wire  logic [3:0]                wb_sel_i,
   input  wire  logic [31:0]               wb_dat_i,
   output logic       [31:0]               wb_dat_o,
   output logic                            wb_ack_o,
   input  wire  gpio_port_pkg::port_byte_t pin_in,
   output gpio_port_pkg::port_byte_t       pin_out,
   output gpio_port_pkg::port_byte_t       pin_oe,
   output gpio_port_pkg::port_byte_t       pullup_on,
   input  wire  logic                      pwm_source,
   input  wire  logic                      timer_f_high_source,
   input  wire  logic                      timer_f_low_source,
   input  wire  logic                      watch_timer_source,
   output logic                            ext_int_three_select,
   output logic                            ext_int_two_select,
   output logic                            ext_int_one_select,
   output logic                            timer_g_input_select,
   output logic                            timer_f_event_input,
   output logic                            timer_c_event_input,
   output logic                            timer_b_event_input,
   output logic                            timer_g_event_input
);
   import gpio_port_pkg::*;

   // ==========================================================
   // parameter check
   if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr_w
      $error("address width too small for register map");
   end

   localparam logic [ADDR_W-1:0] A_FUNC = ADDR_W'(OFF_PIN_FUNCTION_SELECT);
   localparam logic [ADDR_W-1:0] A_DATA = ADDR_W'(OFF_PORT_OUTPUT_DATA);
   localparam logic [ADDR_W-1:0] A_PULL = ADDR_W'(OFF_PULLUP_ENABLE);
   localparam logic [ADDR_W-1:0] A_DIR  = ADDR_W'(OFF_PIN_DIRECTION);

   // ==========================================================
   // register storage
   port_byte_t port_output_data;
   port_byte_t pin_direction;
   port_byte_t pullup_enable;
   port_byte_t pin_function_select;

   // ==========================================================
   // bus decode
   wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
   wire        bus_rd   = bus_req & ~wb_we_i;
   wire        hit_func = (wb_adr_i == A_FUNC);
   wire        hit_data = (wb_adr_i == A_DATA);
   wire        hit_pull = (wb_adr_i == A_PULL);
   wire        hit_dir  = (wb_adr_i == A_DIR);

   // ==========================================================
   // readback selection
   wire [7:0]  port_readback = (pin_direction & port_output_data)
                             | (~pin_direction & pin_in);
   wire [7:0]  read_byte     = hit_func ? pin_function_select
                             : hit_data ? port_readback
                             : hit_pull ? pullup_enable
                             : hit_dir  ? DIRECTION_READBACK
                             : 8'h00;
   wire [31:0] next_dat_o    = bus_rd ? {READ_PAD, read_byte} : wb_dat_o;

   // ==========================================================
   // bus answer: ack one cycle after request, for one cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= next_dat_o;
      end
   end

   // ==========================================================
   // register writes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         port_output_data    <= RST_PORT_OUTPUT_DATA;
         pin_direction       <= RST_PIN_DIRECTION;
         pullup_enable       <= RST_PULLUP_ENABLE;
         pin_function_select <= RST_PIN_FUNCTION_SELECT;
      end else if (bus_wr) begin
         if (hit_data) begin
            port_output_data <= wb_dat_i[7:0];
         end
         if (hit_dir) begin
            pin_direction <= wb_dat_i[7:0];
         end
         if (hit_pull) begin
            pullup_enable <= wb_dat_i[7:0];
         end
         if (hit_func) begin
            pin_function_select <= wb_dat_i[7:0];
         end
      end
   end

   // ==========================================================
   // pin multiplexer
   pin_mux_if mux_bus ();

   assign mux_bus.port_output_data    = port_output_data;
   assign mux_bus.pin_direction       = pin_direction;
   assign mux_bus.pullup_enable       = pullup_enable;
   assign mux_bus.pin_function_select = pin_function_select;
   assign mux_bus.pin_level           = pin_in;
   assign mux_bus.alt_source          = {3'b000, pwm_source, 1'b0, timer_f_high_source,
                                         timer_f_low_source, watch_timer_source};

   pin_mux u_pin_mux (
      .bus (mux_bus.mux)
   );

   // ==========================================================
   // registered pin and peripheral outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pin_out   <= 8'h00;
         pin_oe    <= 8'h00;
         pullup_on <= 8'h00;
      end else begin
         pin_out   <= mux_bus.next_pin_out;
         pin_oe    <= mux_bus.next_pin_oe;
         pullup_on <= mux_bus.next_pullup;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ext_int_three_select <= 1'b0;
         ext_int_two_select   <= 1'b0;
         ext_int_one_select   <= 1'b0;
         timer_g_input_select <= 1'b0;
      end else begin
         ext_int_three_select <= pin_function_select[SEL_EXT_INT_THREE];
         ext_int_two_select   <= pin_function_select[SEL_EXT_INT_TWO];
         ext_int_one_select   <= pin_function_select[SEL_EXT_INT_ONE];
         timer_g_input_select <= pin_function_select[SEL_TIMER_G_INPUT];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         timer_f_event_input <= 1'b0;
         timer_c_event_input <= 1'b0;
         timer_b_event_input <= 1'b0;
         timer_g_event_input <= 1'b0;
      end else begin
         timer_f_event_input <= mux_bus.next_events[EVT_TIMER_F];
         timer_c_event_input <= mux_bus.next_events[EVT_TIMER_C];
         timer_b_event_input <= mux_bus.next_events[EVT_TIMER_B];
         timer_g_event_input <= mux_bus.next_events[EVT_TIMER_G];
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock);
   endclocking

   default disable iff (sys_rst);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence s_wr_data;
      s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == A_DATA);
   endsequence

   sequence s_wr_dir;
      s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == A_DIR);
   endsequence

   sequence s_rd_data;
      s_req ##0 (!wb_we_i && wb_adr_i == A_DATA);
   endsequence

   sequence s_rd_dir;
      s_req ##0 (!wb_we_i && wb_adr_i == A_DIR);
   endsequence

   a_ack_single_pulse: assert property (
      s_req |=> wb_ack_o ##1 !wb_ack_o
   ) else $error("ack not a single cycle pulse after request");

   a_data_write_store: assert property (
      s_wr_data |=> port_output_data == $past(wb_dat_i[7:0])
   ) else $error("output data write not stored");

   a_data_reaches_pin: assert property (
      (s_wr_data ##0 !pin_function_select[0]) ##1 (pin_direction[0]
         && !pin_function_select[0])
      |=> pin_out[0] == $past(port_output_data[0], 1) && pin_oe[0]
   ) else $error("written data not driven on gpio output pin");

   a_read_data_mix: assert property (
      s_rd_data |=> wb_dat_o[7:0] ==
         (($past(pin_direction) & $past(port_output_data))
         | (~$past(pin_direction) & $past(pin_in)))
   ) else $error("data read does not mix latch and pin level");

   a_read_upper_zero: assert property (
      s_req ##0 !wb_we_i |=> wb_dat_o[31:8] == 24'h000000
   ) else $error("upper read bits not zero");

   a_dir_reads_ones: assert property (
      s_rd_dir |=> wb_dat_o[7:0] == 8'hFF
   ) else $error("direction register did not read as all ones");

   a_dir_write_oe: assert property (
      s_wr_dir ##1 (pin_function_select == 8'h00)
      |=> pin_oe == $past(wb_dat_i[7:0], 2)
   ) else $error("direction write did not set output enables");

   a_gpio_follows_regs: assert property (
      ((pin_oe ^ $past(pin_direction)) & ~$past(pin_function_select)) == 8'h00
   ) else $error("gpio output enable differs from direction");

   a_alt_out_drive: assert property (
      $past(pin_function_select[SEL_PWM_OUT])
      |-> pin_oe[4] && pin_out[4] == $past(pwm_source)
   ) else $error("pwm pin not driven from peripheral");

   a_alt_in_release: assert property (
      (pin_oe & $past(pin_function_select) & ALT_INPUT_PINS) == 8'h00
   ) else $error("alternate input pin is being driven");

   a_pullup_gate: assert property (
      pullup_on == ($past(pullup_enable) & ~$past(pin_direction))
   ) else $error("pull-up not gated by direction");

   a_event_route: assert property (
      timer_f_event_input == ($past(pin_function_select[7]) && $past(pin_in[7]))
      && timer_b_event_input == ($past(pin_function_select[5]) && $past(pin_in[5]))
   ) else $error("interrupt and timer input routing wrong");

   a_reset_clear: assert property (
      disable iff (1'b0)
      sys_rst |=> port_output_data == 8'h00 && pin_direction == 8'h00
         && pullup_enable == 8'h00 && pin_function_select == 8'h00
   ) else $error("registers not cleared by reset");

endmodule : port_one_gpio

//--- sim/tb.sv
// self-checking bench for the port one gpio block
`timescale 1ns/1ps
module tb;
   import gpio_port_pkg::*;

   // ==========================================================
   // stimulus and observation
   logic        clock;
   logic        sys_rst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [15:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   port_byte_t  pin_in;
   port_byte_t  pin_out;
   port_byte_t  pin_oe;
   port_byte_t  pullup_on;
   logic [3:0]  src;
   logic [3:0]  sel_out;
   logic [3:0]  evt;
   int          num_errors;
   int          comparisons;

   port_one_gpio #(.ADDR_W(16)) dut (
      .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
      .pwm_source(src[3]), .timer_f_high_source(src[2]), .timer_f_low_source(src[1]),
      .watch_timer_source(src[0]), .ext_int_three_select(sel_out[3]),
      .ext_int_two_select(sel_out[2]), .ext_int_one_select(sel_out[1]),
      .timer_g_input_select(sel_out[0]), .timer_f_event_input(evt[3]),
      .timer_c_event_input(evt[2]), .timer_b_event_input(evt[1]),
      .timer_g_event_input(evt[0])
   );

   // ==========================================================
   // clock and watchdog
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      stop_test();
   end

   // ==========================================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wb_xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                          input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("mismatch ack expected 1 seen timeout");
         stop_test();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb_xfer

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb_xfer(1'b1, a, d, 4'h1, q);
   endtask : wr

   task automatic rd_check(input string what, input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_xfer(1'b0, a, 8'h00, 4'hF, q);
      check(what, q, exp);
   endtask : rd_check

   task automatic settle;
      repeat (3) @(posedge clock);
   endtask : settle

   // ==========================================================
   // scenarios
   task automatic test_reset_values;
      rd_check("data in", OFF_PORT_OUTPUT_DATA, 32'h000000A5);
      rd_check("direction", OFF_PIN_DIRECTION, 32'h000000FF);
      rd_check("pullup", OFF_PULLUP_ENABLE, 32'h00000000);
      rd_check("select", OFF_PIN_FUNCTION_SELECT, 32'h00000000);
      rd_check("unmapped", 16'hFFD0, 32'h00000000);
      check("oe reset", pin_oe, 8'h00);
      check("out reset", pin_out, 8'h00);
   endtask : test_reset_values

   task automatic test_direction_data;
      logic [31:0] q;
      wr(OFF_PORT_OUTPUT_DATA, 8'h5A);
      wr(OFF_PIN_DIRECTION, 8'hF0);
      wb_xfer(1'b1, OFF_PORT_OUTPUT_DATA, 8'hFF, 4'hE, q);
      settle();
      rd_check("data mixed", OFF_PORT_OUTPUT_DATA, 32'h00000055);
      rd_check("direction wo", OFF_PIN_DIRECTION, 32'h000000FF);
      check("oe dir", pin_oe, 8'hF0);
      check("out latch", pin_out, 8'h5A);
      check("pins all", {pin_oe, pin_out}, 16'hF05A);
   endtask : test_direction_data

   task automatic test_pullup;
      wr(OFF_PULLUP_ENABLE, 8'hFF);
      settle();
      check("pullup dir", pullup_on, 8'h0F);
      wr(OFF_PULLUP_ENABLE, 8'h3C);
      settle();
      check("pullup mask", pullup_on, 8'h0C);
      rd_check("pullup rd", OFF_PULLUP_ENABLE, 32'h0000003C);
   endtask : test_pullup

   task automatic test_alt_functions;
      src <= 4'b1011;
      wr(OFF_PIN_FUNCTION_SELECT, 8'hFF);
      settle();
      rd_check("select rd", OFF_PIN_FUNCTION_SELECT, 32'h000000FF);
      check("alt oe", pin_oe, 8'h17);
      check("alt out", pin_out, 8'h13);
      check("alt selects", sel_out, 4'hF);
      check("alt events", evt, 4'hA);
      src <= 4'b0100;
      pin_in <= 8'h48;
      settle();
      check("alt out two", pin_out, 8'h04);
      check("alt events two", evt, 4'h5);
      wr(OFF_PIN_FUNCTION_SELECT, 8'h00);
      settle();
      check("gpio oe", pin_oe, 8'hF0);
      check("gpio out", pin_out, 8'h5A);
      check("gpio selects", {sel_out, evt}, 8'h00);
   endtask : test_alt_functions

   task automatic test_second_reset;
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd_check("pullup rst", OFF_PULLUP_ENABLE, 32'h00000000);
      check("oe rst", pin_oe, 8'h00);
   endtask : test_second_reset

   // ==========================================================
   // closing
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   initial begin
      num_errors  = 0;
      comparisons = 0;
      sys_rst     = 1'b1;
      cyc         = 1'b0;
      stb         = 1'b0;
      we          = 1'b0;
      adr         = 16'h0000;
      sel         = 4'h0;
      wdat        = 32'h00000000;
      pin_in      = 8'hA5;
      src         = 4'h0;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      test_reset_values();
      test_direction_data();
      test_pullup();
      test_alt_functions();
      test_second_reset();
      stop_test();
   end

endmodule : tb
